/* File: include/ddr2_mode_pkg.sv */
`default_nettype none
package ddr2_mode_pkg;

    // ----------------------------------------------------------------
    // Pin bundle and mode field layout
    // ----------------------------------------------------------------
    localparam int ADDR_W   = 16;
    localparam int BA_W     = 3;
    localparam int MODE_W   = 13;
    localparam int LAT_W    = 4;
    localparam int PIPE_LEN = 16;

    typedef struct packed {
        logic              csN;
        logic              rasN;
        logic              casN;
        logic              weN;
        logic              cke;
        logic              odt;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
    } pins_s;

    typedef enum logic [1:0] {RTT_OFF, RTT_75, RTT_150, RTT_50} rtt_e;

    // Command codes on {csN, rasN, casN, weN}.
    localparam logic [3:0] CMD_LM  = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;

    // Mode register select on {BA1, BA0}.
    localparam logic [1:0] BA_MR   = 2'h0;
    localparam logic [1:0] BA_EMR  = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;
    localparam logic [1:0] BA_EMR3 = 2'h3;

    localparam int MR_CL_LO     = 4;
    localparam int MR_CL_HI     = 6;
    localparam int MR_DLL_RST   = 8;
    localparam int EMR_DLL_OFF  = 0;
    localparam int EMR_RTT_LO   = 2;
    localparam int EMR_RTT_HI   = 6;
    localparam int EMR_AL_LO    = 3;
    localparam int EMR_AL_HI    = 5;
    localparam int EMR_OCD_LO   = 7;
    localparam int EMR_OCD_HI   = 9;
    localparam int EMR2_SRF     = 7;
    localparam int PRE_ALL_BIT  = 10;

    localparam logic [2:0] OCD_DEFAULT = 3'h7;

    // ----------------------------------------------------------------
    // Timing counts in link clock edges
    // ----------------------------------------------------------------
    localparam logic [7:0] DLL_LOCK_CYC = 8'hC8;
    localparam logic [3:0] ODT_EMR_HOLD = 4'h8;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MODES  = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;
    localparam logic [7:0] REG_LAT    = 8'h0C;
    localparam logic       CTRL_RESET = 1'h1;

endpackage
`default_nettype wire

/* File: logic/ddr2_mode_init.sv */
// Overview of operation
// - Termination value chosen from two EMR bits
// - Termination pin obeyed only when enabled, not self-refresh
// - Additive latency field zero to six clocks
// - Early read/write delayed internally by additive latency
// - Read data after additive plus CAS latency
// - Write latency is read latency minus one
// - DLL reset load needs 200 clocks lock
// - Ready 200 clocks after DLL reset
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ddr2_mode_init
    import ddr2_mode_pkg::*;
(
    input  wire logic        ref_clk,          // system clock, 50 MHz
    input  wire logic        rst_n,            // synchronous reset
    input  wire logic        ckPin,            // link clock pin
    input  wire pins_s       pinsIn,           // command, address, CKE, ODT
    input  wire logic [7:0]  regAddr,          // register byte address
    input  wire logic [31:0] regWrData,        // register write data
    input  wire logic        regWr,            // register write strobe
    input  wire logic        regRd,            // register read strobe
    output var  logic [31:0] regRdData,        // read data, next cycle
    output var  logic        termOn,           // termination switched in
    output var  rtt_e        rttSel,           // selected termination value
    output var  logic        readDataStart,    // first read data edge
    output var  logic        writeSampleStart, // first write sample edge
    output var  logic        devReady          // DLL locked, ready
);

    // ----------------------------------------------------------------
    // Pin synchronisers and link clock edge
    // ----------------------------------------------------------------
    pins_s pinMeta;
    pins_s pinSync;
    logic  ckMeta;
    logic  ckSync;
    logic  ckLast;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
            ckMeta  <= 1'b0;
            ckSync  <= 1'b0;
            ckLast  <= 1'b0;
        end
        else
        begin
            pinMeta <= pinsIn;
            pinSync <= pinMeta;
            ckMeta  <= ckPin;
            ckSync  <= ckMeta;
            ckLast  <= ckSync;
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic       ckePrev;
    wire        ckRise   = ckSync & ~ckLast;
    wire  [3:0] cmdCode  = {pinSync.csN, pinSync.rasN,
                            pinSync.casN, pinSync.weN};
    wire  [1:0] baSel    = pinSync.ba[1:0];
    wire        cmdLive  = ckRise & pinSync.cke & ckePrev;
    wire        isLm     = cmdLive & (cmdCode == CMD_LM);
    wire        isRd     = cmdLive & (cmdCode == CMD_RD);
    wire        isWr     = cmdLive & (cmdCode == CMD_WR);
    wire        srEnter  = ckRise & ckePrev & ~pinSync.cke
                           & (cmdCode == CMD_REF);
    wire        srExit   = ckRise & ~ckePrev & pinSync.cke;
    wire        isDllRst = isLm & (baSel == BA_MR)
                           & pinSync.addr[MR_DLL_RST];
    wire  [1:0] newRtt   = {pinSync.addr[EMR_RTT_HI],
                            pinSync.addr[EMR_RTT_LO]};

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    // Bank bit 2 and address bits above 12 are dropped on load because the
    // controller must keep them zero; storing them would gain nothing.
    logic [MODE_W-1:0] mr;
    logic [MODE_W-1:0] emr;
    logic [MODE_W-1:0] emr2;
    logic [MODE_W-1:0] emr3;
    logic              selfRefresh;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mr   <= '0;
            emr  <= '0;
            emr2 <= '0;
            emr3 <= '0;
        end
        else if (isLm && baSel == BA_MR)
            mr   <= pinSync.addr[MODE_W-1:0];
        else if (isLm && baSel == BA_EMR)
            emr  <= pinSync.addr[MODE_W-1:0];
        else if (isLm && baSel == BA_EMR2)
            emr2 <= pinSync.addr[MODE_W-1:0];
        else if (isLm && baSel == BA_EMR3)
            emr3 <= pinSync.addr[MODE_W-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ckePrev     <= 1'b0;
            selfRefresh <= 1'b0;
        end
        else
        begin
            if (ckRise)
                ckePrev <= pinSync.cke;
            if (srEnter)
                selfRefresh <= 1'b1;
            else if (srExit)
                selfRefresh <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Latency
    // ----------------------------------------------------------------
    // Reserved encodings of the latency fields are not trapped; a reserved
    // CAS field can give a read latency that never fires.
    logic [PIPE_LEN-1:0] rdPipe;
    logic [PIPE_LEN-1:0] wrPipe;
    wire [2:0]       casLat  = mr[MR_CL_HI:MR_CL_LO];
    wire [2:0]       addLat  = emr[EMR_AL_HI:EMR_AL_LO];
    wire [LAT_W-1:0] readLat = LAT_W'(casLat) + LAT_W'(addLat);
    wire [LAT_W-1:0] wrLat   = readLat - LAT_W'(1);
    wire [LAT_W-1:0] rdIdx   = readLat - LAT_W'(1);
    wire [LAT_W-1:0] wrIdx   = wrLat - LAT_W'(1);
    wire             rdHit   = (readLat != '0) & rdPipe[rdIdx];
    wire             wrHit   = (wrLat != '0) & wrPipe[wrIdx];

    // Commands are taken at once, even ahead of the row delay, and each is
    // held back in the pipe by its read or write latency (posted plus CAS, less one for writes) before it acts.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdPipe           <= '0;
            wrPipe           <= '0;
            readDataStart    <= 1'b0;
            writeSampleStart <= 1'b0;
        end
        else
        begin
            if (ckRise)
            begin
                rdPipe <= {rdPipe[PIPE_LEN-2:0], isRd};
                wrPipe <= {wrPipe[PIPE_LEN-2:0], isWr};
            end
            readDataStart    <= ckRise & rdHit;
            writeSampleStart <= ckRise & wrHit;
        end
    end

    // ----------------------------------------------------------------
    // Termination
    // ----------------------------------------------------------------
    logic [3:0] odtHold;
    logic       termAllow;
    wire        termEnabled = (rttSel != RTT_OFF);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rttSel  <= RTT_OFF;
            termOn  <= 1'b0;
            odtHold <= '0;
        end
        else
        begin
            rttSel <= rtt_e'({emr[EMR_RTT_HI], emr[EMR_RTT_LO]});
            if (isLm && baSel == BA_EMR && newRtt != 2'h0)
                odtHold <= ODT_EMR_HOLD;
            else if (ckRise && odtHold != '0)
                odtHold <= odtHold - 4'h1;
            // The pin is ignored in self refresh and before the EMR turns
            // termination on, so a stray high cannot load the bus.
            termOn <= termEnabled & termAllow & pinSync.odt
                      & ~selfRefresh & (odtHold == '0);
        end
    end

    // ----------------------------------------------------------------
    // DLL lock and ready
    // ----------------------------------------------------------------
    logic [7:0] dllCnt;
    logic       dllSeen;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dllCnt   <= '0;
            dllSeen  <= 1'b0;
            devReady <= 1'b0;
        end
        else
        begin
            if (isDllRst)
            begin
                dllCnt  <= DLL_LOCK_CYC;
                dllSeen <= 1'b1;
            end
            else if (ckRise && dllCnt != '0)
                dllCnt <= dllCnt - 8'h01;
            devReady <= dllSeen & (dllCnt == '0) & ~isDllRst
                        & ~emr[EMR_DLL_OFF];
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    logic [31:0] readMux;

    always_comb
    begin
        readMux = '0;
        if (regAddr == REG_STATUS)
            readMux = {25'h0, devReady, (dllCnt != '0), selfRefresh,
                       ~ckePrev, termOn, rttSel};
        else if (regAddr == REG_MODES)
            readMux = {21'h0, emr[EMR_DLL_OFF],
                       (emr[EMR_OCD_HI:EMR_OCD_LO] == OCD_DEFAULT),
                       emr2[EMR2_SRF], 1'h0, addLat, 1'h0, casLat};
        else if (regAddr == REG_CTRL)
            readMux = {31'h0, termAllow};
        else if (regAddr == REG_LAT)
            readMux = {24'h0, wrLat, readLat};
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            regRdData <= '0;
            termAllow <= CTRL_RESET;
        end
        else
        begin
            regRdData <= regRd ? readMux : 32'h0;
            if (regWr && regAddr == REG_CTRL)
                termAllow <= regWrData[0];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [7:0] rdEdges;
    logic [7:0] wrEdges;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdEdges <= '0;
            wrEdges <= '0;
        end
        else
        begin
            if (isRd)
                rdEdges <= '0;
            else if (ckRise && rdEdges != 8'hFF)
                rdEdges <= rdEdges + 8'h01;
            if (isWr)
                wrEdges <= '0;
            else if (ckRise && wrEdges != 8'hFF)
                wrEdges <= wrEdges + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_RTT_FROM_EMR: assert property (
        isLm && baSel == BA_EMR |-> ##2 rttSel == rtt_e'($past(newRtt, 2)))
        else $error("termination value does not follow EMR load");
    AST_TERM_SELF_REFRESH: assert property (
        selfRefresh |-> ##1 !termOn)
        else $error("termination on during self refresh");
    AST_TERM_DISABLED: assert property (
        rttSel == RTT_OFF |=> !termOn)
        else $error("termination on while disabled in EMR");
    AST_AL_LOAD: assert property (
        isLm && baSel == BA_EMR
        |=> addLat == $past(pinSync.addr[EMR_AL_HI:EMR_AL_LO]))
        else $error("additive latency not taken from EMR load");
    AST_POSTED_SUM: assert property (
        readDataStart |-> $past(rdEdges) + 8'h01 == addLat + casLat)
        else $error("read not delayed by additive latency");
    AST_READ_LAT: assert property (
        readDataStart |-> $past(rdEdges) == 8'(casLat) + 8'(addLat) - 8'h01)
        else $error("first read data at wrong edge");
    AST_WRITE_LAT: assert property (
        writeSampleStart |-> $past(wrEdges) + 8'h02 == 8'(readLat))
        else $error("write sampling not one clock before read latency");
    AST_DLL_LOAD: assert property (
        isDllRst |=> dllCnt == DLL_LOCK_CYC ##1 !devReady[*8])
        else $error("DLL reset did not restart lock count");
    AST_READY_AFTER_LOCK: assert property (
        $rose(devReady) |-> $past(dllCnt) == '0 && dllSeen)
        else $error("ready before DLL lock count ran out");

    COV_READ: cover property (isRd ##[1:300] readDataStart);
    COV_WRITE: cover property (isWr ##[1:300] writeSampleStart);
    COV_TERM: cover property ($rose(termOn));
    COV_READY: cover property ($rose(devReady));

endmodule
`default_nettype wire

/* File: bench/ddr2_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ddr2_ctl_model
    import ddr2_mode_pkg::*;
(
    input  wire logic  ref_clk, // system clock
    output var  logic  ckPin,   // link clock, eight system clocks a period
    output var  pins_s pinsIn   // command, address, CKE and ODT pins
);
    logic [1:0] phase;

    // --------------------------------------------------------------
    // Link clock, free running as the memory clock must be
    // --------------------------------------------------------------
    initial
    begin
        phase  = 2'h1;
        ckPin  = 1'b0;
        pinsIn = {4'hF, 1'b0, 1'b0, 3'h0, 16'h0};
    end

    always @(posedge ref_clk)
    begin
        phase <= phase + 2'h1;
        if (phase == 2'h3)
        begin
            ckPin <= ~ckPin;
        end
    end

    // --------------------------------------------------------------
    // Pin tasks
    // --------------------------------------------------------------
    // Pins move on the falling link edge so they are steady at the
    // sampling edge; released address lines flip so a stale value is
    // never read as a held one.
    task automatic send(input logic [3:0] cmd, input logic [2:0] ba,
                        input logic [15:0] addr);
        @(negedge ckPin);
        @(posedge ref_clk);
        {pinsIn.csN, pinsIn.rasN, pinsIn.casN, pinsIn.weN} <= cmd;
        pinsIn.ba   <= ba;
        pinsIn.addr <= addr;
        @(negedge ckPin);
        @(posedge ref_clk);
        {pinsIn.csN, pinsIn.rasN, pinsIn.casN, pinsIn.weN} <= 4'hF;
        pinsIn.addr <= ~addr;
    endtask

    // Self refresh entry needs the refresh code and the CKE fall on one edge.
    task automatic enterSr();
        @(negedge ckPin);
        @(posedge ref_clk);
        {pinsIn.csN, pinsIn.rasN, pinsIn.casN, pinsIn.weN} <= CMD_REF;
        pinsIn.cke <= 1'b0;
        @(negedge ckPin);
        @(posedge ref_clk);
        {pinsIn.csN, pinsIn.rasN, pinsIn.casN, pinsIn.weN} <= 4'hF;
    endtask

    task automatic setLine(input logic cke, input logic odt);
        @(negedge ckPin);
        @(posedge ref_clk);
        pinsIn.cke <= cke;
        pinsIn.odt <= odt;
    endtask
endmodule
`default_nettype wire

/* File: bench/ddr2_mode_init_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module ddr2_mode_init_test
    import ddr2_mode_pkg::*;
;
    logic        ref_clk;
    logic        rst_n;
    logic        ckPin;
    pins_s       pinsIn;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdData;
    logic        termOn;
    rtt_e        rttSel;
    logic        readDataStart;
    logic        writeSampleStart;
    logic        devReady;
    int          errors;
    int          comparisons;
    int          n;
    logic [2:0]  al;
    logic [2:0]  cl;
    logic        e7;

    // 1250 link periods of 160 ns give the NOP span before CKE rises.
    localparam int NOP_CK   = 1250;
    localparam int LIMIT_NS = 160 * (NOP_CK + 1000);

    ddr2_ctl_model i_ctl (.ref_clk(ref_clk), .ckPin(ckPin), .pinsIn(pinsIn));

    ddr2_mode_init i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ckPin(ckPin), .pinsIn(pinsIn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .termOn(termOn),
        .rttSel(rttSel), .readDataStart(readDataStart),
        .writeSampleStart(writeSampleStart), .devReady(devReady)
    );

    // --------------------------------------------------------------
    // Expectations and bus tasks
    // --------------------------------------------------------------
    function automatic logic [15:0] emrAddr(input logic [1:0] rtt,
                                            input logic [2:0] a,
                                            input logic ocd);
        return {6'h0, {3{ocd}}, rtt[1], a, rtt[0], 2'h0};
    endfunction

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [31:0] mask);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        `CHK("regRdData", exp, regRdData & mask)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    // Counts link rises after the command edge until the pulse shows.
    task automatic measure(input logic wrSel, output int cnt);
        logic last;
        cnt  = 0;
        last = ckPin;
        for (int t = 0; t < 300; t++)
        begin
            @(posedge ref_clk);
            #1;
            cnt  = cnt + int'(ckPin && !last);
            last = ckPin;
            if ((wrSel ? writeSampleStart : readDataStart) === 1'b1)
                break;
        end
    endtask

    task automatic settle();
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial
    begin
        #(LIMIT_NS);
        errors++;
        report_and_stop();
    end

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        errors = 0;
        comparisons = 0;
        void'($urandom(32'h11f012be));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdChk(REG_STATUS, 32'h0, 32'h47);
        rdChk(REG_CTRL, 32'h1, 32'h1);
        rdChk(8'hFC, 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        repeat (NOP_CK) @(negedge ckPin);
        i_ctl.setLine(1'b1, 1'b0);
        repeat (3) @(posedge ckPin);
        i_ctl.send(CMD_PRE, 3'h0, 16'h0400);
        e7 = 1'($urandom_range(1, 0));
        i_ctl.send(CMD_LM, {1'b0, BA_EMR2}, {8'h0, e7, 7'h0});
        i_ctl.send(CMD_LM, {1'b0, BA_EMR3}, 16'h0);
        i_ctl.send(CMD_LM, {1'b0, BA_EMR}, 16'h0);
        i_ctl.send(CMD_LM, {1'b0, BA_MR}, 16'h0100);
        i_ctl.send(CMD_PRE, 3'h0, 16'h0400);
        i_ctl.send(CMD_REF, 3'h0, 16'h0);
        i_ctl.send(CMD_REF, 3'h0, 16'h0);
        al = 3'h2;
        cl = 3'h4;
        i_ctl.send(CMD_LM, {1'b0, BA_MR}, {9'h0, cl, 4'h0});
        i_ctl.send(CMD_LM, {1'b0, BA_EMR}, emrAddr(2'h3, al, 1'b1));
        rdChk(REG_MODES, {22'h0, 1'b1, e7, 1'b0, al, 1'b0, cl}, 32'h777);
        i_ctl.send(CMD_LM, {1'b0, BA_EMR}, emrAddr(2'h3, al, 1'b0));
        rdChk(REG_MODES, {22'h0, 1'b0, e7, 1'b0, al, 1'b0, cl}, 32'h777);
        $display("test init done");
        i_ctl.setLine(1'b1, 1'b1);
        settle();
        `CHK("termOn", 1'b0, termOn)
        repeat (9) @(posedge ckPin);
        settle();
        `CHK("termOn", 1'b1, termOn)
        wr(REG_CTRL, 32'h0);
        settle();
        `CHK("termOn", 1'b0, termOn)
        wr(REG_CTRL, 32'h1);
        i_ctl.setLine(1'b1, 1'b0);
        settle();
        `CHK("termOn", 1'b0, termOn)
        $display("test termination done");
        repeat (150) @(posedge ckPin);
        `CHK("devReady", 1'b0, devReady)
        repeat (30) @(posedge ckPin);
        settle();
        `CHK("devReady", 1'b1, devReady)
        i_ctl.setLine(1'b1, 1'b0);
        i_ctl.enterSr();
        i_ctl.setLine(1'b0, 1'b1);
        settle();
        rdChk(REG_STATUS, 32'h10, 32'h14);
        `CHK("termOn", 1'b0, termOn)
        i_ctl.setLine(1'b1, 1'b0);
        settle();
        rdChk(REG_STATUS, 32'h0, 32'h10);
        $display("test self refresh done");
        for (int c = 0; c < 4; c++)
        begin
            i_ctl.send(CMD_LM, {1'b0, BA_EMR}, emrAddr(2'(c), al, 1'b0));
            settle();
            `CHK("rttSel", rtt_e'(c), rttSel)
        end
        $display("test resistance done");
        for (int i = 0; i < 6; i++)
        begin
            al = (i == 0) ? 3'h6 : (i == 1) ? 3'h0 : 3'($urandom_range(6, 0));
            cl = (i == 0) ? 3'h7 : (i == 1) ? 3'h3 : 3'($urandom_range(7, 3));
            i_ctl.send(CMD_LM, {1'b0, BA_MR}, {9'h0, cl, 4'h0});
            i_ctl.send(CMD_LM, {1'b0, BA_EMR}, emrAddr(2'h0, al, 1'b0));
            rdChk(REG_LAT, {24'h0, 4'(al + cl - 1), 4'(al + cl)}, 32'hFF);
            i_ctl.send(CMD_RD, 3'h0, 16'h0);
            measure(1'b0, n);
            `CHK("readLatency", int'(al) + int'(cl), n)
            i_ctl.send(CMD_WR, 3'h0, 16'h0);
            measure(1'b1, n);
            `CHK("writeLatency", int'(al) + int'(cl) - 1, n)
        end
        $display("test latency done");
        report_and_stop();
    end
endmodule
`default_nettype wire
